// ==== crc_pkg.sv ====
package crc_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL1     = 8'h00;
  localparam logic [7:0] ADDR_CTRL2     = 8'h04;
  localparam logic [7:0] ADDR_MASK_LO   = 8'h08;
  localparam logic [7:0] ADDR_MASK_HI   = 8'h0c;
  localparam logic [7:0] ADDR_DATA      = 8'h10;
  localparam logic [7:0] ADDR_RESULT    = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h18;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_CLR   = 8'h20;

  // Control register 1 field positions
  localparam int BIT_ENABLE    = 15;
  localparam int BIT_IDLE_STOP = 13;
  localparam int CNT_LSB       = 8;
  localparam int BIT_FULL      = 7;
  localparam int BIT_EMPTY     = 6;
  localparam int BIT_ISEL      = 5;
  localparam int BIT_GO        = 4;
  localparam int BIT_ENDIAN    = 3;
  // Control register 2 field positions
  localparam int DW_LSB        = 8;
  localparam int PLEN_LSB      = 0;

  // Interrupt status bits
  localparam int IRQ_CRC  = 0;
  localparam int IRQ_DROP = 1;
  localparam int IRQ_W    = 2;

  // FIFO geometry
  localparam int          WORD_W         = 32;
  localparam int          FIFO_AW        = 4;
  localparam logic [4:0]  PLEN_SHORT_MAX = 5'h07;
  localparam logic [4:0]  DEPTH_LONG     = 5'h08;
  localparam logic [4:0]  DEPTH_SHORT    = 5'h10;

  // Values after reset
  localparam logic [4:0]  FIELD_RST  = 5'h00;
  localparam logic [15:0] MASK_RST   = 16'h0000;
  localparam logic [31:0] RESULT_RST = 32'h0000_0000;
  localparam logic [1:0]  IRQ_RST    = 2'h0;

  typedef enum logic [2:0] {
    st_idle  = 3'b001,
    st_load  = 3'b010,
    st_shift = 3'b100
  } eng_state_e;
endpackage

// ==== crc_fifo_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
module crc_fifo_mem
(
  input  wire logic                          i_core_clk,
  input  wire logic                          i_rst,
  input  wire logic                          i_wr_en,
  input  wire logic [crc_pkg::FIFO_AW-1:0]   i_wr_addr,
  input  wire logic [crc_pkg::WORD_W-1:0]    i_wr_data,
  input  wire logic                          i_rd_en,
  input  wire logic [crc_pkg::FIFO_AW-1:0]   i_rd_addr,
  output logic      [crc_pkg::WORD_W-1:0]    o_rd_data
);
  import crc_pkg::*;

  logic [WORD_W-1:0] mem [2**FIFO_AW];

  // Storage has no reset; words are only read after being written
  always_ff @(posedge i_core_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  // Registered read, one cycle after the request
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rd_data <= RESULT_RST;
    end else if (i_rd_en) begin
      o_rd_data <= mem[i_rd_addr];
    end
  end
endmodule
`default_nettype wire

// ==== crc_fifo_control_status.sv ====
// What this block does
// [R1] Read-only five-bit count of valid words in the input FIFO.
// [R2] Polynomial length field above 7 limits the FIFO to 8 words.
// [R3] Polynomial length field of 7 or less allows 16 words.
// [R4] Idle-stop clear keeps running in CPU idle; set pauses the engine.
// [R5] Full flag reads 1 while FIFO holds its current maximum.
// [R6] Empty means count zero; full means count equals current depth.
// [R7] Polynomial order is length field plus one, up to 32 bits.
// [R8] Each data word is data width field plus one bits wide.
// [R9] Feedback XOR tap at each mask bit set, none where clear; bit 0 is always tapped.
`timescale 1ns/1ps
`default_nettype none
module crc_fifo_control_status
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_cpu_idle,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_irq
);
  import crc_pkg::*;

  logic              enable;
  logic              idle_stop;
  logic              isel;
  logic              go;
  logic              endian;
  logic [4:0]        dwidth;
  logic [4:0]        plen;
  logic [15:0]       mask_lo;
  logic [15:0]       mask_hi;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_en;
  logic [FIFO_AW-1:0] wr_ptr;
  logic [FIFO_AW-1:0] rd_ptr;
  logic [4:0]        count;
  logic [31:0]       crc;
  logic [31:0]       shreg;
  logic [4:0]        bit_cnt;
  eng_state_e        state;
  logic [WORD_W-1:0] rd_data;

  logic        setup_acc;
  logic        commit;
  logic        wr;
  logic        mapped;
  logic [4:0]  depth;
  logic        full;
  logic        empty;
  logic        push;
  logic        drop;
  logic        pop;
  logic        run;
  logic        step;
  logic        word_done;
  logic        din;
  logic        fb;
  logic [31:0] poly;
  logic [31:0] width_mask;
  logic [31:0] next_crc;
  logic [IRQ_W-1:0] irq_evt;

  // Bus phases; writes land on the edge the master sees pready
  assign setup_acc = i_psel & i_penable & ~o_pready;
  assign commit    = i_psel & i_penable & o_pready;
  assign wr        = commit & i_pwrite;
  assign mapped    = (i_paddr <= ADDR_IRQ_CLR) && (i_paddr[1:0] == 2'b00);

  // Depth follows polynomial length
  assign depth = (plen > PLEN_SHORT_MAX) ? DEPTH_LONG : DEPTH_SHORT; // [R2] [R3]
  assign full  = (count == depth); // [R5] [R6]
  assign empty = (count == 5'h00); // [R6]

  // A write into a full FIFO is dropped and flagged rather than overwriting
  assign push = wr && (i_paddr == ADDR_DATA) && enable && !full; // [R2] [R3]
  assign drop = wr && (i_paddr == ADDR_DATA) && enable && full;

  // With go set, the engine pauses only when idle-stop is set and the CPU is idle
  assign run       = enable && go && !(i_cpu_idle && idle_stop); // [R4]
  assign pop       = (state == st_idle) && run && !empty;
  assign step      = (state == st_shift) && run;
  assign word_done = step && (bit_cnt == dwidth); // [R8]

  // Serial CRC step, order is plen+1 bits
  assign din        = endian ? shreg[0] : shreg[dwidth]; // [R8]
  assign fb         = crc[plen] ^ din; // [R7]
  assign poly       = {mask_hi, mask_lo[15:1], 1'b1}; // [R9]
  assign width_mask = ~(32'hffff_fffe << plen); // [R7]
  assign next_crc   = ({crc[30:0], 1'b0} ^ (fb ? poly : 32'h0000_0000)) & width_mask; // [R9]

  // Interrupt source chosen by isel
  assign irq_evt[IRQ_CRC]  = isel ? (pop && (count == 5'h01) && !push)
                                  : (word_done && empty && !push);
  assign irq_evt[IRQ_DROP] = drop;

  crc_fifo_mem u_mem (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_wr_en    (push),
    .i_wr_addr  (wr_ptr),
    .i_wr_data  (i_pwdata),
    .i_rd_en    (pop),
    .i_rd_addr  (rd_ptr),
    .o_rd_data  (rd_data)
  );

  // Control register writes
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      enable    <= 1'b0;
      idle_stop <= 1'b0;
      isel      <= 1'b0;
      go        <= 1'b0;
      endian    <= 1'b0;
      dwidth    <= FIELD_RST;
      plen      <= FIELD_RST;
      mask_lo   <= MASK_RST;
      mask_hi   <= MASK_RST;
      irq_en    <= IRQ_RST;
    end else if (wr) begin
      if (i_paddr == ADDR_CTRL1) begin
        enable    <= i_pwdata[BIT_ENABLE];
        idle_stop <= i_pwdata[BIT_IDLE_STOP]; // [R4]
        isel      <= i_pwdata[BIT_ISEL];
        go        <= i_pwdata[BIT_GO];
        endian    <= i_pwdata[BIT_ENDIAN];
      end
      if (i_paddr == ADDR_CTRL2) begin
        dwidth <= i_pwdata[DW_LSB +: 5];
        plen   <= i_pwdata[PLEN_LSB +: 5];
      end
      if (i_paddr == ADDR_MASK_LO) begin
        mask_lo <= i_pwdata[15:0];
      end
      if (i_paddr == ADDR_MASK_HI) begin
        mask_hi <= i_pwdata[15:0];
      end
      if (i_paddr == ADDR_IRQ_EN) begin
        irq_en <= i_pwdata[IRQ_W-1:0];
      end
    end
  end

  // FIFO pointers and count; disable empties everything
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !enable) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= 5'h00;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == FIFO_AW'(depth - 5'h01)) ? '0 : wr_ptr + 1'b1; // [R2] [R3]
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == FIFO_AW'(depth - 5'h01)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + {4'h0, push} - {4'h0, pop}; // [R1]
    end
  end

  // Shift engine; holds its place in st_idle and st_shift while paused in idle, but st_load still advances to st_shift
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !enable) begin
      state   <= st_idle;
      shreg   <= RESULT_RST;
      bit_cnt <= FIELD_RST;
    end else begin
      unique case (state)
        st_idle: begin
          if (pop) begin
            state <= st_load;
          end
        end
        st_load: begin
          shreg   <= rd_data;
          bit_cnt <= FIELD_RST;
          state   <= st_shift;
        end
        st_shift: begin
          if (step) begin // [R4]
            shreg   <= endian ? (shreg >> 1) : (shreg << 1);
            bit_cnt <= bit_cnt + 5'h01;
            if (word_done) begin
              state <= st_idle; // [R8]
            end
          end
        end
      endcase
    end
  end

  // Result word; software may seed it only while the engine is idle
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !enable) begin
      crc <= RESULT_RST;
    end else if (step) begin
      crc <= next_crc; // [R7] [R9]
    end else if (wr && (i_paddr == ADDR_RESULT) && (state == st_idle)) begin
      crc <= i_pwdata & width_mask;
    end
  end

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      irq_stat <= IRQ_RST;
    end else if (wr && (i_paddr == ADDR_IRQ_CLR)) begin
      irq_stat <= (irq_stat & ~i_pwdata[IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat <= irq_stat | irq_evt;
    end
  end

  // Level interrupt, one cycle behind status
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_stat & irq_en);
    end
  end

  // Bus answer: one wait state, read data captured in the first access cycle
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= setup_acc;
      o_pslverr <= setup_acc && !mapped;
      if (setup_acc) begin
        unique case (i_paddr)
          ADDR_CTRL1: o_prdata <= {16'h0000, enable, 1'b0, idle_stop, count, // [R1]
                                   full, empty, isel, go, endian, 3'b000}; // [R5] [R6]
          ADDR_CTRL2: o_prdata <= {19'h0, dwidth, 3'b000, plen};
          ADDR_MASK_LO: o_prdata <= {16'h0000, mask_lo};
          ADDR_MASK_HI: o_prdata <= {16'h0000, mask_hi};
          ADDR_RESULT: o_prdata <= crc;
          ADDR_IRQ_STAT: o_prdata <= {30'h0, irq_stat};
          ADDR_IRQ_EN: o_prdata <= {30'h0, irq_en};
          default: o_prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  count_bound_a: assert property (count <= depth) // [R1]
    else $error("fifo count above depth");
  long_depth_a: assert property ((plen > PLEN_SHORT_MAX) && (count == DEPTH_LONG) && !pop
                                 && wr && (i_paddr == ADDR_DATA) |=> count == DEPTH_LONG) // [R2]
    else $error("long polynomial fifo took a ninth word");
  short_depth_a: assert property ((plen <= PLEN_SHORT_MAX) && (count == 5'h08) && push && !pop
                                  |=> (count == 5'h09) && !full) // [R3]
    else $error("short polynomial fifo stopped at eight");
  idle_stop_a: assert property ((state == st_shift) && i_cpu_idle && idle_stop
                                |=> $stable(crc) && $stable(bit_cnt)) // [R4]
    else $error("engine moved while stopped in idle");
  idle_run_a: assert property ((state == st_shift) && enable && go && !idle_stop && !word_done
                               |=> bit_cnt == $past(bit_cnt) + 5'h01) // [R4]
    else $error("engine stalled in idle with idle-stop clear");
  full_read_a: assert property (setup_acc && (i_paddr == ADDR_CTRL1) && !i_pwrite
                                |=> o_prdata[BIT_FULL] == (o_prdata[CNT_LSB +: 5] == $past(depth))) // [R5]
    else $error("full flag disagrees with count");
  empty_read_a: assert property (setup_acc && (i_paddr == ADDR_CTRL1)
                                 |=> o_prdata[BIT_EMPTY] == (o_prdata[CNT_LSB +: 5] == 5'h00)) // [R6]
    else $error("empty flag disagrees with count");
  crc_order_a: assert property (step |=> (crc & ~$past(width_mask)) == 32'h0000_0000) // [R7]
    else $error("crc bits set above polynomial order");
  word_width_a: assert property ((state == st_load) ##1 (step && dwidth == 5'h00)
                                 |=> state == st_idle) // [R8]
    else $error("one-bit word took more than one shift");
  tap_apply_a: assert property (step && fb |=> crc == (({$past(crc[30:0]), 1'b0} ^ $past(poly))
                                & $past(width_mask))) // [R9]
    else $error("feedback taps not applied from mask");
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import crc_pkg::*;
  logic        i_core_clk, i_rst, i_cpu_idle, i_psel, i_penable, i_pwrite;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic        o_pready, o_pslverr, o_irq;
  logic [64:0] note;
  logic [64:0] notes[$];
  logic [7:0]  words[$];
  int          num_errors, n_compared, cycles, k;

  crc_fifo_control_status u_crc_fifo_control_status (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_cpu_idle(i_cpu_idle), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq));

  // Free-running 10 MHz clock
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end

  // Hang guard, generous against the few hundred cycles needed
  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end

  // Completed transfer: oldest note holds {slave error, care mask, value}
  always @(negedge i_core_clk) begin
    if (i_psel && i_penable && o_pready === 1'b1 && notes.size() > 0) begin
      note = notes.pop_front();
      compare_bus(note);
    end
  end

  task automatic compare_bus(input logic [64:0] n);
    n_compared++;
    if ((o_prdata & n[63:32]) !== n[31:0] || o_pslverr !== n[64]) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, {o_pslverr, o_prdata & n[63:32]}, {n[64], n[31:0]});
    end
  endtask

  task automatic compare_irq(input logic exp);
    repeat (2) @(posedge i_core_clk);
    @(negedge i_core_clk);
    n_compared++;
    if (o_irq !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, o_irq, exp);
    end
  endtask

  // One APB transfer; waits for pready with a bound, then releases
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic e);
    int n;
    @(posedge i_core_clk);
    notes.push_back({e, (w ? 32'h0 : m), (w ? 32'h0 : d & m)});
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= w;
    i_paddr   <= a;
    i_pwdata  <= w ? d : $urandom;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    n = 0;
    // Sampled at the rising edge; release only after pready is seen there
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (o_pready !== 1'b1) begin
      num_errors++;
      end_of_test();
    end
    rd = o_prdata;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e = 1'b0);
    apb(1'b1, a, d, 32'h0, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = 32'hffff_ffff,
                     input logic e = 1'b0);
    apb(1'b0, a, d, m, e);
  endtask

  // Bus stays busy until the watched bits are all set
  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    k = 0;
    do begin
      rdc(a, 32'h0, 32'h0);
      k++;
    end while ((rd & m) !== m && k < 200);
    if ((rd & m) !== m) begin
      num_errors++;
      end_of_test();
    end
  endtask

  task automatic push_words(input int n);
    for (int i = 0; i < n; i++) begin
      words.push_back(8'($urandom));
      wr(ADDR_DATA, {24'h0, words[$]});
    end
  endtask

  // Bench copy of the serial CRC, MSB first, for a given order and word width
  function automatic logic [31:0] crc_ref(input int i0, input int n, input int ord, input int wb,
                                          input logic [31:0] p);
    logic [31:0] c;
    logic        fb;
    c = 32'h0000_0000;
    for (int i = i0; i < i0 + n; i++) begin
      for (int b = wb - 1; b >= 0; b--) begin
        fb = c[ord - 1] ^ words[i][b];
        c  = ({c[30:0], 1'b0} ^ (fb ? p : 32'h0000_0000)) & (32'hffff_ffff >> (32 - ord));
      end
    end
    return c;
  endfunction

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    i_rst = 1'b1; i_cpu_idle = 1'b0; i_psel = 1'b0; i_penable = 1'b0;
    i_pwrite = 1'b0; i_paddr = 8'h00; i_pwdata = 32'h0;
    num_errors = 0; n_compared = 0; cycles = 0;
    void'($urandom(32'h03ee));
    repeat (4) @(posedge i_core_clk);
    i_rst <= 1'b0;
    rdc(ADDR_CTRL1, 32'h0000_0040);
    rdc(8'h24, 32'h0, 32'hffff_ffff, 1'b1);
    wr(8'h06, 32'h1, 1'b1);
    wr(ADDR_CTRL2, 32'h0000_070f);
    rdc(ADDR_CTRL2, 32'h0000_070f);
    wr(ADDR_MASK_LO, 32'h0000_1021);
    wr(ADDR_MASK_HI, 32'h0000_0000);
    // Long polynomial: ninth word must be dropped
    wr(ADDR_CTRL1, 32'h0000_8000);
    push_words(9);
    rdc(ADDR_CTRL1, 32'h0000_8880);
    rdc(ADDR_IRQ_STAT, 32'h0000_0002);
    wr(ADDR_IRQ_EN, 32'h0000_0002);
    compare_irq(1'b1);
    wr(ADDR_IRQ_EN, 32'h0000_0000);
    compare_irq(1'b0);
    wr(ADDR_IRQ_CLR, 32'h0000_0002);
    rdc(ADDR_IRQ_STAT, 32'h0000_0000);
    // Idle with stop set freezes a word mid-shift; clearing it lets it drain in idle
    wr(ADDR_CTRL1, 32'h0000_a010);
    repeat (3) @(posedge i_core_clk);
    i_cpu_idle <= 1'b1;
    repeat (40) @(posedge i_core_clk);
    rdc(ADDR_CTRL1, 32'h0000_a710);
    wr(ADDR_IRQ_EN, 32'h0000_0001);
    wr(ADDR_CTRL1, 32'h0000_8010);
    poll(ADDR_IRQ_STAT, 32'h0000_0001);
    compare_irq(1'b1);
    rdc(ADDR_CTRL1, 32'h0000_8050);
    rdc(ADDR_RESULT, crc_ref(0, 8, 16, 8, 32'h0000_1021));
    // Short polynomial: sixteen words fit, seventeenth dropped
    wr(ADDR_CTRL1, 32'h0000_0000);
    wr(ADDR_IRQ_CLR, 32'h0000_0003);
    compare_irq(1'b0);
    wr(ADDR_CTRL2, 32'h0000_0707);
    wr(ADDR_CTRL1, 32'h0000_8000);
    push_words(17);
    rdc(ADDR_CTRL1, 32'h0000_9080);
    rdc(ADDR_IRQ_STAT, 32'h0000_0002);
    // One-bit words on an eight-bit polynomial: one shift per word
    wr(ADDR_CTRL1, 32'h0000_0000);
    wr(ADDR_CTRL2, 32'h0000_0007);
    wr(ADDR_CTRL1, 32'h0000_8000);
    push_words(2);
    wr(ADDR_CTRL1, 32'h0000_8010);
    poll(ADDR_IRQ_STAT, 32'h0000_0001);
    rdc(ADDR_RESULT, crc_ref(words.size() - 2, 2, 8, 1, 32'h0000_1021));
    end_of_test();
  end
endmodule
`default_nettype wire
